// ===== verilog/rco_pkg.sv
// Package of constants for the reference clock output divider
package rco_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int RCO_ADDR_W = 12;
   localparam int RCO_DATA_W = 32;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] RCO_OFS_CTRL = 12'h000;
   localparam logic [11:0] RCO_OFS_STAT = 12'h004;
   localparam logic [11:0] RCO_OFS_PCNT = 12'h008;

   // ------------------------------------------------------------
   // Control register layout and reset values
   // ------------------------------------------------------------
   localparam int RCO_DIV_W = 3;
   localparam int RCO_DUTY_W = 2;
   localparam int RCO_EN_BIT = 7;
   localparam int RCO_DUTY_LSB = 3;
   localparam int RCO_DIV_LSB = 0;
   localparam logic RCO_EN_RESET = 1'b0;
   localparam logic [1:0] RCO_DUTY_RESET = 2'h2;
   localparam logic [2:0] RCO_DIV_RESET = 3'h0;

   // ------------------------------------------------------------
   // Status register layout
   // ------------------------------------------------------------
   localparam int RCO_ST_RUN_BIT = 0;
   localparam int RCO_ST_LEVEL_BIT = 1;
   localparam int RCO_ST_HOLD_BIT = 2;
   localparam int RCO_ST_LIVE_BIT = 3;

   // ------------------------------------------------------------
   // Duty codes and counter geometry
   // ------------------------------------------------------------
   localparam logic [1:0] RCO_DUTY_0 = 2'h0;
   localparam logic [1:0] RCO_DUTY_25 = 2'h1;
   localparam logic [1:0] RCO_DUTY_50 = 2'h2;
   localparam logic [1:0] RCO_DUTY_75 = 2'h3;
   localparam int RCO_CNT_W = 8;
   localparam int RCO_PCNT_W = 16;
   localparam logic [7:0] RCO_CNT_PARK = 8'hff;

endpackage

// ===== verilog/rco_wavegen.sv
// Power-of-two divider and duty shaper for the reference clock
`timescale 1ns/1ps
`default_nettype none
module rco_wavegen
   import rco_pkg::*;
#(
   parameter int CNT_W = rco_pkg::RCO_CNT_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic hold,
   input wire logic [rco_pkg::RCO_DIV_W-1:0] div_sel,
   input wire logic [rco_pkg::RCO_DUTY_W-1:0] duty_sel,
   output logic wave,
   output logic tick
);
   // ------------------------------------------------------------
   // Period and high time
   // ------------------------------------------------------------
   logic [CNT_W-1:0] cnt;
   wire [CNT_W-1:0] period_len;
   wire [CNT_W-1:0] last_idx;
   wire [CNT_W-1:0] quarter;
   wire [CNT_W-1:0] high_len;
   wire [CNT_W-1:0] next_cnt;
   wire next_wave;

   assign period_len = CNT_W'(1) << div_sel;
   assign last_idx = period_len - CNT_W'(1);
   assign quarter = period_len >> 2;
   // Divide by two has no quarter step, so every nonzero duty becomes half
   assign high_len = (duty_sel == RCO_DUTY_0) ? CNT_W'(0) :
      (div_sel == 3'h1) ? CNT_W'(1) :
      (duty_sel == RCO_DUTY_25) ? quarter :
      (duty_sel == RCO_DUTY_50) ? (period_len >> 1) :
      (period_len - quarter);
   // Parked counter wraps to zero, so each start opens a whole period
   assign next_cnt = (cnt >= last_idx) ? CNT_W'(0) : cnt + CNT_W'(1);
   // Undivided rate ignores the duty field
   assign next_wave = (div_sel == 3'h0) ? 1'b1 :
      (next_cnt < high_len);

   // ------------------------------------------------------------
   // Counter and output flops
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt <= CNT_W'(RCO_CNT_PARK);
         wave <= 1'b0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt <= CNT_W'(RCO_CNT_PARK);
         wave <= 1'b0;
         tick <= 1'b0;
      end else if (!hold) begin
         cnt <= next_cnt;
         wave <= next_wave;
         tick <= (next_cnt == CNT_W'(0));
      end
   end
endmodule
`default_nettype wire

// ===== verilog/rco_top.sv
// Reference clock output divider with its APB register slave
//
// Notes on behaviour
// - The system clock is the one and only source of the divider.
// - A system clock switch shows on the output with no reconfiguration.
// - The generated clock drives the dedicated reference clock pin.
// - The generated clock is also offered to on-chip users.
// - Start after enable is glitch-free, opening with a whole period.
// - Clearing the enable turns the output off at once.
// - A three-bit field picks division by 1, 2, 4 up to 128.
// - Duty picks 0, 25, 50 or 75 percent high time, ignored when undivided; at divide by 2 any nonzero duty gives 50 percent.
// - Divider and duty stay writable while enabled and act at once.
// - Reset loads the upper duty bit with one, giving 50 percent.
// - In sleep the pin and internal clock keep their present level; the tick stays low.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rco_top
   import rco_pkg::*;
#(
   parameter int CNT_W = rco_pkg::RCO_CNT_W,
   parameter int PCNT_W = rco_pkg::RCO_PCNT_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rco_pkg::RCO_ADDR_W-1:0] paddr,
   input wire logic [rco_pkg::RCO_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [rco_pkg::RCO_DATA_W-1:0] prdata,
   output logic pslverr,
   input wire logic sleep_req,
   output logic ref_clock_out_pin,
   output logic refclk_internal,
   output logic refclk_tick
);
   import rco_pkg::*;

   typedef enum logic [1:0] {
      RCO_ST_IDLE,
      RCO_ST_RUN,
      RCO_ST_SLEEP
   } rco_state_e;

   // ------------------------------------------------------------
   // Decoding helper
   // ------------------------------------------------------------
   function automatic logic rco_hit(input logic [RCO_ADDR_W-1:0] a,
                                    input logic [RCO_ADDR_W-1:0] ofs);
      rco_hit = (a == ofs);
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic refclk_module_enable;
   logic [RCO_DIV_W-1:0] refclk_divide_select;
   logic [RCO_DUTY_W-1:0] refclk_duty_select;
   logic live_change;
   logic [PCNT_W-1:0] period_count;
   logic sleep_meta;
   logic sleep_sync;
   rco_state_e state;
   rco_state_e next_state;
   logic gen_wave;
   logic gen_tick;

   wire hit_ctrl;
   wire hit_stat;
   wire hit_pcnt;
   wire hit_any;
   wire setup_phase;
   wire wr_commit;
   wire wr_ctrl;
   wire wr_stat;
   wire wr_pcnt;
   wire next_enable;
   wire [RCO_DIV_W-1:0] next_div;
   wire [RCO_DUTY_W-1:0] next_duty;
   wire cfg_touched;
   wire gen_run;
   wire gen_hold;
   wire [RCO_DATA_W-1:0] ctrl_word;
   wire [RCO_DATA_W-1:0] stat_word;
   wire [RCO_DATA_W-1:0] pcnt_word;
   wire [RCO_DATA_W-1:0] read_word;

   // ------------------------------------------------------------
   // Sleep request crossing
   // ------------------------------------------------------------
   // The request is asynchronous; only the second stage is read
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sleep_meta <= 1'b0;
         sleep_sync <= 1'b0;
      end else begin
         sleep_meta <= sleep_req;
         sleep_sync <= sleep_meta;
      end
   end

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign hit_ctrl = rco_hit(paddr, RCO_OFS_CTRL);
   assign hit_stat = rco_hit(paddr, RCO_OFS_STAT);
   assign hit_pcnt = rco_hit(paddr, RCO_OFS_PCNT);
   assign hit_any = hit_ctrl | hit_stat | hit_pcnt;
   assign setup_phase = psel & ~penable;
   assign wr_commit = psel & penable & pready & pwrite & hit_any;
   assign wr_ctrl = wr_commit & hit_ctrl & pstrb[0];
   assign wr_stat = wr_commit & hit_stat & pstrb[0];
   assign wr_pcnt = wr_commit & hit_pcnt;

   // ------------------------------------------------------------
   // Next control values
   // ------------------------------------------------------------
   // Enable is taken from the write itself, so a clear stops the
   // divider at the same edge that stores the bit
   assign next_enable = wr_ctrl ? pwdata[RCO_EN_BIT] :
      refclk_module_enable;
   assign next_div = wr_ctrl ?
      pwdata[RCO_DIV_LSB +: RCO_DIV_W] : refclk_divide_select;
   assign next_duty = wr_ctrl ?
      pwdata[RCO_DUTY_LSB +: RCO_DUTY_W] : refclk_duty_select;
   // Live edits are allowed but flagged, as they may glitch
   assign cfg_touched = wr_ctrl & refclk_module_enable & next_enable &
      ((next_div != refclk_divide_select) |
       (next_duty != refclk_duty_select));

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         refclk_module_enable <= RCO_EN_RESET;
         refclk_divide_select <= RCO_DIV_RESET;
         refclk_duty_select <= RCO_DUTY_RESET;
      end else begin
         refclk_module_enable <= next_enable;
         refclk_divide_select <= next_div;
         refclk_duty_select <= next_duty;
      end
   end

   // ------------------------------------------------------------
   // Live change flag, set wins over write-one-to-clear
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         live_change <= 1'b0;
      end else if (cfg_touched) begin
         live_change <= 1'b1;
      end else if (wr_stat & pwdata[RCO_ST_LIVE_BIT]) begin
         live_change <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Run state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         RCO_ST_IDLE: begin
            if (next_enable) begin
               next_state = sleep_sync ? RCO_ST_SLEEP : RCO_ST_RUN;
            end
         end
         RCO_ST_RUN: begin
            if (!next_enable) begin
               next_state = RCO_ST_IDLE;
            end else if (sleep_sync) begin
               next_state = RCO_ST_SLEEP;
            end
         end
         RCO_ST_SLEEP: begin
            if (!next_enable) begin
               next_state = RCO_ST_IDLE;
            end else if (!sleep_sync) begin
               next_state = RCO_ST_RUN;
            end
         end
         default: begin
            next_state = RCO_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= RCO_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Sleep freezes the divider but a disable still wins
   assign gen_run = next_enable;
   assign gen_hold = sleep_sync;

   // ------------------------------------------------------------
   // Divider and duty shaper
   // ------------------------------------------------------------
   rco_wavegen #(
      .CNT_W(CNT_W)
   ) u_wavegen (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .run(gen_run),
      .hold(gen_hold),
      .div_sel(next_div),
      .duty_sel(next_duty),
      .wave(gen_wave),
      .tick(gen_tick)
   );

   // ------------------------------------------------------------
   // Output flops
   // ------------------------------------------------------------
   // Mirroring the shaper costs one cycle of latency; pin and internal
   // copy keep their level while the divider is frozen, the tick is held low
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ref_clock_out_pin <= 1'b0;
         refclk_internal <= 1'b0;
         refclk_tick <= 1'b0;
      end else begin
         ref_clock_out_pin <= gen_wave;
         refclk_internal <= gen_wave;
         refclk_tick <= gen_tick & ~gen_hold;
      end
   end

   // ------------------------------------------------------------
   // Started period counter
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         period_count <= '0;
      end else if (wr_pcnt) begin
         period_count <= '0;
      end else if (gen_tick & ~gen_hold) begin
         period_count <= period_count + PCNT_W'(1);
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   assign ctrl_word = {24'h000000, refclk_module_enable, 2'h0,
                       refclk_duty_select, refclk_divide_select};
   assign stat_word = {28'h0000000, live_change, sleep_sync,
                       ref_clock_out_pin, (state != RCO_ST_IDLE)};
   assign pcnt_word = {{(RCO_DATA_W-PCNT_W){1'b0}}, period_count};
   assign read_word = hit_ctrl ? ctrl_word :
      hit_stat ? stat_word :
      hit_pcnt ? pcnt_word : 32'h00000000;

   // ------------------------------------------------------------
   // APB answer: one access cycle, no waits
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h00000000 : read_word;
         pslverr <= ~hit_any;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== test/rco_monitor.sv
// Checker for the reference clock divider ports
`timescale 1ns/1ps
`default_nettype none
module rco_monitor
   import rco_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rco_pkg::RCO_ADDR_W-1:0] paddr,
   input wire logic [rco_pkg::RCO_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic sleep_req,
   input wire logic ref_clock_out_pin,
   input wire logic refclk_internal,
   input wire logic refclk_tick
);
   // ------------------------------------------------------------
   // Shadow of the control word and settling counters
   // ------------------------------------------------------------
   logic wr, ok, en_q, live_q, seen;
   logic [2:0] div_q;
   logic [1:0] duty_q;
   logic [7:0] age, calm, tcnt, hcnt;
   assign wr = psel && penable && pready && pwrite && pstrb[0]
      && paddr == RCO_OFS_CTRL;
   // Live changes and sleep may glitch, so judge only settled spans
   assign ok = age > 8'h03 && calm > 8'h03;
   function automatic logic [7:0] exp_h(input logic [2:0] d,
      input logic [1:0] c);
      return (d == 3'h1) ? 8'h01 : 8'((32'(c) << d) >> 2);
   endfunction
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         en_q <= 1'b0;
         live_q <= 1'b0;
         div_q <= 3'h0;
         duty_q <= 2'h2;
         age <= 8'h00;
      end else if (wr) begin
         en_q <= pwdata[7];
         live_q <= en_q;
         div_q <= pwdata[2:0];
         duty_q <= pwdata[4:3];
         age <= 8'h00;
      end else if (age != 8'hff) begin
         age <= age + 8'h01;
      end
   end
   // Known start values, or every settled-span check stays vacuous
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         calm <= 8'h00;
         tcnt <= 8'h00;
         hcnt <= 8'h00;
         seen <= 1'b0;
      end else begin
         calm <= sleep_req ? 8'h00 : calm + 8'(calm != 8'hff);
         tcnt <= refclk_tick ? 8'h01 : tcnt + 8'(tcnt != 8'hff);
         hcnt <= ref_clock_out_pin ? hcnt + 8'h01 : 8'h00;
         seen <= ok && (seen || refclk_tick);
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence on_wr_s;
      wr && pwdata[7] && !en_q && pwdata[4:3] != 2'h0 && calm > 8'h03;
   endsequence
   sequence off_wr_s;
      wr && !pwdata[7];
   endsequence
   sequence dozing_s;
      sleep_req [*6] ##0 age > 8'h03;
   endsequence
   ready_next_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   copy_same_a: assert property (refclk_internal == ref_clock_out_pin)
      else $error("internal copy differs from pin");
   start_clean_a: assert property (on_wr_s |-> ##1 !ref_clock_out_pin
      ##1 ref_clock_out_pin) else $error("bad start after enable");
   stop_fast_a: assert property (off_wr_s |-> ##2 !ref_clock_out_pin)
      else $error("output not off after disable");
   off_low_a: assert property (!en_q && ok |-> !ref_clock_out_pin)
      else $error("output active while disabled");
   duty_zero_a: assert property (en_q && ok && duty_q == 2'h0
      && div_q != 3'h0 |-> !ref_clock_out_pin) else $error("duty zero high");
   undiv_high_a: assert property (en_q && ok && div_q == 3'h0
      |-> ref_clock_out_pin && refclk_tick) else $error("undivided wrong");
   tick_gap_a: assert property (en_q && ok && seen && refclk_tick
      |-> tcnt == (8'h01 << div_q)) else $error("period length wrong");
   high_len_a: assert property (en_q && $fell(ref_clock_out_pin)
      && (age > hcnt + 8'h01 || !live_q) && calm > hcnt + 8'h04
      |-> hcnt == exp_h(div_q, duty_q)) else $error("high time wrong");
   sleep_hold_a: assert property (dozing_s |-> $stable(ref_clock_out_pin))
      else $error("pin moved in sleep");
   sleep_tick_a: assert property (sleep_req [*6] |-> !refclk_tick)
      else $error("tick in sleep");
endmodule
bind rco_top rco_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .sleep_req(sleep_req), .ref_clock_out_pin(ref_clock_out_pin),
   .refclk_internal(refclk_internal), .refclk_tick(refclk_tick));
`default_nettype wire

// ===== test/rco_load.sv
// Pin load model measuring the reference clock waveform
`timescale 1ns/1ps
`default_nettype none
module rco_load (
   input wire logic sys_clk,
   input wire logic pin,
   input wire logic int_clk,
   output var logic [7:0] period,
   output var logic [7:0] high,
   output var logic differ
);
   logic last = 1'b0;
   logic [7:0] cnt = 8'h00;
   logic [7:0] hc = 8'h00;
   initial begin
      period = 8'h00;
      high = 8'h00;
      differ = 1'b0;
   end
   // Rise to rise gives the period, rise to fall the high time
   always @(posedge sys_clk) begin
      last <= pin;
      cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
      hc <= pin ? hc + 8'h01 : 8'h00;
      if (pin !== int_clk) differ <= 1'b1;
      if (pin && !last) begin
         period <= cnt;
         cnt <= 8'h01;
      end
      if (!pin && last) high <= hc;
   end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking testbench for the reference clock divider
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rco_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic sleep_req = 1'b0;
   logic pready, pslverr, pin, int_clk, tick, differ, e;
   logic [31:0] prdata, q;
   logic [7:0] period, high;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   realtime half = 4.0;
   always #(half) sys_clk = ~sys_clk;
   rco_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sleep_req(sleep_req), .ref_clock_out_pin(pin),
      .refclk_internal(int_clk), .refclk_tick(tick));
   rco_load far (.sys_clk(sys_clk), .pin(pin), .int_clk(int_clk),
      .period(period), .high(high), .differ(differ));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h", $time, what, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] exp_h(input int d, input int c);
      return (d == 1) ? 32'h1 : 32'((c << d) / 4);
   endfunction
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check(32'(pin), 32'h0, "pin after reset");
      apb(1'b0, RCO_OFS_CTRL, 32'h0);
      check(q, 32'h10, "control reset");
      apb(1'b1, 12'h0fc, 32'h9b);
      check(32'(e), 32'h1, "unmapped error");
      pstrb <= 4'he;
      apb(1'b1, RCO_OFS_CTRL, 32'h9b);
      pstrb <= 4'hf;
      check(32'(e), 32'h0, "mapped no error");
      apb(1'b0, RCO_OFS_CTRL, 32'h0);
      check(q, 32'h10, "control untouched");
      $display("test reset done");
   endtask
   task automatic t_rates();
      for (int d = 0; d < 8; d++) begin
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, RCO_OFS_CTRL, 32'(c * 8 + d));
            apb(1'b1, RCO_OFS_CTRL, 32'(128 + c * 8 + d));
            repeat (3 * (1 << d) + 6) @(posedge sys_clk);
            if (d == 0) check(32'(pin), 32'h1, "undivided");
            else if (c == 0) check(32'(pin), 32'h0, "duty zero");
            else begin
               check(32'(period), 32'(1 << d), "period");
               check(32'(high), exp_h(d, c), "high time");
            end
            apb(1'b1, RCO_OFS_CTRL, 32'(c * 8 + d));
            repeat (2) @(posedge sys_clk);
            check(32'(pin), 32'h0, "off at once");
         end
      end
      $display("test rates done");
   endtask
   task automatic t_live();
      apb(1'b1, RCO_OFS_PCNT, 32'h0);
      apb(1'b0, RCO_OFS_PCNT, 32'h0);
      check(q, 32'h0, "count cleared");
      apb(1'b1, RCO_OFS_CTRL, 32'h92);
      // Two periods of four cycles have begun before the count is read
      repeat (5) @(posedge sys_clk);
      apb(1'b0, RCO_OFS_PCNT, 32'h0);
      check(q, 32'h2, "period count");
      repeat (20) @(posedge sys_clk);
      apb(1'b1, RCO_OFS_CTRL, 32'h93);
      repeat (40) @(posedge sys_clk);
      check(32'(period), 32'h8, "live period");
      apb(1'b0, RCO_OFS_STAT, 32'h0);
      check(32'(q[RCO_ST_LIVE_BIT]), 32'h1, "live flag");
      apb(1'b1, RCO_OFS_STAT, 32'h8);
      apb(1'b0, RCO_OFS_STAT, 32'h0);
      check(32'(q[RCO_ST_LIVE_BIT]), 32'h0, "live flag cleared");
      check(32'(q[RCO_ST_RUN_BIT]), 32'h1, "running");
      $display("test live done");
   endtask
   task automatic t_sleep();
      logic v;
      sleep_req <= 1'b1;
      repeat (8) @(posedge sys_clk);
      v = pin;
      repeat (30) @(posedge sys_clk);
      check(32'(pin), 32'(v), "held in sleep");
      check(32'(tick), 32'h0, "no tick in sleep");
      sleep_req <= 1'b0;
      repeat (40) @(posedge sys_clk);
      check(32'(high), 32'h4, "resumed high");
      $display("test sleep done");
   endtask
   task automatic t_switch();
      realtime t0;
      half = 6.0;
      repeat (40) @(posedge sys_clk);
      check(32'(period), 32'h8, "period on new clock");
      @(posedge pin);
      t0 = $realtime;
      @(posedge pin);
      check(int'($realtime - t0), 32'd96, "period in time");
      check(32'(differ), 32'h0, "copies agree");
      half = 4.0;
      apb(1'b1, RCO_OFS_CTRL, 32'h13);
      $display("test switch done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Ceiling well above the few thousand cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_rates();
      t_live();
      t_sleep();
      t_switch();
      test_done();
   end
endmodule
`default_nettype wire
